// ==== nsbc_pkg.sv ====
// Constants, field layouts and types for the null-seeking balance control.
// Assumes a single 10 MHz clock and a plain strobed register port.
package nsbc_pkg;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_HZ   = 10_000_000;               // Clock rate in Hz
    localparam int HOLD_MS  = 50;                       // Settling hold-off, ms
    localparam int HOLD_CYC = HOLD_MS * (CLK_HZ / 1000); // Hold-off in cycles
    localparam int HOLD_W   = 20;                       // Hold counter width

    // =====================================================================
    // Decade positions
    // =====================================================================
    localparam int         NDEC       = 4;       // Units, tens, hundreds, thousands
    localparam logic [3:0] POS_ZERO   = 4'h0;    // Home position
    localparam logic [3:0] POS_ONE    = 4'h1;    // One step
    localparam logic [3:0] POS_TENTH  = 4'ha;    // Tenth position, shown as nine
    localparam logic [15:0] POS_RST   = 16'h0000; // All decades at zero

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [1:0] ADDR_CTRL   = 2'h0;   // Polarity, range, standby
    localparam logic [1:0] ADDR_DIGITS = 2'h1;   // Four decade positions
    localparam logic [1:0] ADDR_STAT   = 2'h2;   // Step path state
    localparam int         CTRL_W      = 4;      // Control field width
    localparam logic [3:0] CTRL_RST    = 4'h0;   // Normal polarity, div 1, active

    // Range codes, also the decimal point position
    localparam logic [1:0] RNG_DIV1   = 2'h0;    // Input divided by one
    localparam logic [1:0] RNG_DIV10  = 2'h1;    // Input divided by ten
    localparam logic [1:0] RNG_DIV100 = 2'h2;    // Input divided by one hundred

    // =====================================================================
    // Types
    // =====================================================================
    typedef struct packed {
        logic       standby;                     // Bit 3: ignore all requests
        logic [1:0] range;                       // Bits 2:1: attenuator choice
        logic       pol_neg;                     // Bit 0: opposite polarity
    } nsbc_ctrl_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,                         // Waiting for a sample
        ST_RAISE = 4'h2,                         // Raise line latched
        ST_LOWER = 4'h4,                         // Lower line latched
        ST_HOLD  = 4'h8                          // Settling hold-off
    } nsbc_state_t;

endpackage : nsbc_pkg

// ==== nsbc_top.sv ====
// Null-seeking balance controller for a four-decade tracking voltmeter.
// Assumes comparator, line reference and step-complete arrive unsynchronised.
//
// What this block does
// - Each step goes out on raise or lower
// - Route each step by all decade positions
// - Fill decades upward, lower clears highest full one
// - Decade position directly drives its displayed digit
// - One comparison sample per line cycle
// - Raise uses comparison, lower its inverse
// - Ignore comparison during negative line half
// - Block new comparisons for hold-off after step
// - Active path blocks the opposite path
// - Step line latched until step complete
// - Step end starts settling one-shot
// - Polarity swaps paths, reference sign, sign lamp
// - Range picks division and decimal point
// - Over range: lower decades stuck, thousands rotating
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module nsbc_top
    import nsbc_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC          // Settling hold-off in cycles
) (
    input  wire logic        MCLK_I,             // 10 MHz clock
    input  wire logic        RST_N_I,            // Async reset, active low
    input  wire logic        CMP_SIGN_I,         // High: input above divider
    input  wire logic        CMP_NULL_I,         // High: difference within band
    input  wire logic        LINE_I,             // High in positive line half
    input  wire logic        STEP_DONE_I,        // Any mechanism stepped
    input  wire logic [1:0]  ADDR_I,             // Register address
    input  wire logic [7:0]  WDATA_I,            // Write data
    input  wire logic        WR_I,               // Write strobe
    input  wire logic        RD_I,               // Read strobe
    output logic      [15:0] RDATA_O,            // Read data, cycle after RD_I
    output logic             RAISE_O,            // Raise step line
    output logic             LOWER_O,            // Lower step line
    output logic      [15:0] DIGITS_O,           // Four decade positions
    output logic             REF_NEG_O,          // Reference sign reversed
    output logic             SIGN_PLUS_O,        // Plus sign lamp
    output logic             SIGN_MINUS_O,       // Minus sign lamp
    output logic      [1:0]  RANGE_O,            // Attenuator selection
    output logic      [1:0]  DP_O                // Decimal point position
);

    // =====================================================================
    // Input synchronisers
    // =====================================================================
    logic [2:0] meta_q;                          // First stage, read only by sync
    logic [2:0] sync_q;                          // Second stage
    logic       line_prev_q;                     // Line level one cycle back
    logic       done_prev_q;                     // Step-complete one cycle back
    logic       cmp_sign_s;                      // Synced comparison sign
    logic       line_rise;                       // Start of positive half
    logic       done_evt;                        // Step completed this cycle

    // Two flops on comparison sign, line and step-complete inputs
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            meta_q      <= 3'h0;
            sync_q      <= 3'h0;
            line_prev_q <= 1'b0;
            done_prev_q <= 1'b0;
        end else begin
            meta_q      <= {STEP_DONE_I, LINE_I, CMP_SIGN_I};
            sync_q      <= meta_q;
            line_prev_q <= sync_q[1];
            done_prev_q <= sync_q[2];
        end
    end

    assign cmp_sign_s = sync_q[0];
    // One sample at the start of each positive half only
    assign line_rise  = sync_q[1] & ~line_prev_q;
    // Every rising contact closure is one completed step
    assign done_evt   = sync_q[2] & ~done_prev_q;

    // =====================================================================
    // Control register
    // =====================================================================
    nsbc_ctrl_t ctrl_q;                          // Polarity, range, standby
    nsbc_ctrl_t ctrl_d;                          // Next control value
    nsbc_ctrl_t wr_ctrl;                         // Written field view

    // Next control value on a write
    always_comb begin
        wr_ctrl = nsbc_ctrl_t'(WDATA_I[CTRL_W-1:0]);
        ctrl_d  = ctrl_q;
        if (WR_I && ADDR_I == ADDR_CTRL) begin
            ctrl_d = wr_ctrl;
            // Unused range code falls back to the largest division
            if (wr_ctrl.range > RNG_DIV100) begin
                ctrl_d.range = RNG_DIV100;
            end
        end
    end

    // Register the control value
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_q <= nsbc_ctrl_t'(CTRL_RST);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // =====================================================================
    // Step path state machine
    // =====================================================================
    nsbc_state_t       state_q;                  // Current path state
    nsbc_state_t       state_d;                  // Next path state
    logic [HOLD_W-1:0] hold_q;                   // Hold-off cycles left
    logic [HOLD_W-1:0] hold_d;                   // Next hold count
    logic              diff;                     // Raise direction after polarity
    logic              null_q;                   // Dead-band flag, second stage
    logic              null_m_q;                 // Dead-band flag, first stage
    logic              trig_up;                  // Raise request accepted
    logic              trig_dn;                  // Lower request accepted

    // Dead-band flag passes its own two flops
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            null_m_q <= 1'b0;
            null_q   <= 1'b0;
        end else begin
            null_m_q <= CMP_NULL_I;
            null_q   <= null_m_q;
        end
    end

    // Polarity swaps which sign means raise
    assign diff    = cmp_sign_s ^ ctrl_q.pol_neg;
    // Raise follows the difference, lower its inverse
    assign trig_up = line_rise & ~null_q & ~ctrl_q.standby & diff;
    assign trig_dn = line_rise & ~null_q & ~ctrl_q.standby & ~diff;

    // Next state: one path at a time, latched until step complete
    always_comb begin
        state_d = state_q;
        hold_d  = hold_q;
        unique case (state_q)
            ST_IDLE: begin
                // Only idle accepts a sample, so the paths exclude each other
                if (trig_up) begin
                    state_d = ST_RAISE;
                end else if (trig_dn) begin
                    state_d = ST_LOWER;
                end
            end
            ST_RAISE, ST_LOWER: begin
                // Step complete clears the latch and fires the one-shot
                if (done_evt) begin
                    state_d = ST_HOLD;
                    hold_d  = HOLD_W'(HOLD_CYCLES - 1);
                end
            end
            ST_HOLD: begin
                // Comparisons blocked until settling time has run out
                if (hold_q == '0) begin
                    state_d = ST_IDLE;
                end else begin
                    hold_d = hold_q - 1'b1;
                end
            end
        endcase
    end

    // Register the path state
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            hold_q  <= '0;
        end else begin
            state_q <= state_d;
            hold_q  <= hold_d;
        end
    end

    // =====================================================================
    // Decade position counters
    // =====================================================================
    logic [15:0] pos_q;                          // Positions, units in low nibble
    logic [15:0] pos_d;                          // Next positions

    // Pick the decade from all positions and step it
    function automatic logic [15:0] nsbc_next_pos(input logic [15:0] p,
                                                  input logic        up);
        logic [15:0] r;
        logic        hit;
        r   = p;
        hit = 1'b0;
        // Raise fills the lowest decade not yet at tenth
        for (int i = 0; i < NDEC - 1; i++) begin
            if (up && !hit && p[i*4 +: 4] != POS_TENTH) begin
                r[i*4 +: 4] = p[i*4 +: 4] + POS_ONE;
                hit         = 1'b1;
            end
        end
        // Lower returns the highest full decade to zero
        for (int i = NDEC - 2; i >= 0; i--) begin
            if (!up && !hit && p[i*4 +: 4] == POS_TENTH) begin
                r[i*4 +: 4] = POS_ZERO;
                hit         = 1'b1;
            end
        end
        // Otherwise thousands moves and wraps, so it keeps rotating
        if (!hit) begin
            if (up) begin
                r[15:12] = (p[15:12] == POS_TENTH) ? POS_ZERO : p[15:12] + POS_ONE;
            end else begin
                r[15:12] = (p[15:12] == POS_ZERO) ? POS_TENTH : p[15:12] - POS_ONE;
            end
        end
        return r;
    endfunction : nsbc_next_pos

    // Apply the step to the routed decade when it completes
    always_comb begin
        pos_d = pos_q;
        if (done_evt && state_q == ST_RAISE) begin
            pos_d = nsbc_next_pos(pos_q, 1'b1);
        end else if (done_evt && state_q == ST_LOWER) begin
            pos_d = nsbc_next_pos(pos_q, 1'b0);
        end
    end

    // Register the positions
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pos_q <= POS_RST;
        end else begin
            pos_q <= pos_d;
        end
    end

    // =====================================================================
    // Register read port
    // =====================================================================
    logic [15:0] rdata_d;                        // Next read data

    // Decode the read; unmapped addresses read zero
    always_comb begin
        rdata_d = 16'h0000;
        if (RD_I) begin
            unique case (ADDR_I)
                ADDR_CTRL:   rdata_d = {12'h000, ctrl_q};
                ADDR_DIGITS: rdata_d = pos_q;
                ADDR_STAT:   rdata_d = {12'h000, state_q};
                default:     rdata_d = 16'h0000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RDATA_O <= 16'h0000;
        end else begin
            RDATA_O <= rdata_d;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign RAISE_O      = (state_q == ST_RAISE);
    assign LOWER_O      = (state_q == ST_LOWER);
    assign DIGITS_O     = pos_q;
    assign REF_NEG_O    = ctrl_q.pol_neg;
    assign SIGN_PLUS_O  = ~ctrl_q.pol_neg;
    assign SIGN_MINUS_O = ctrl_q.pol_neg;
    assign RANGE_O      = ctrl_q.range;
    assign DP_O         = ctrl_q.range;

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    a_paths_exclusive: assert property (!(RAISE_O && LOWER_O))
        else $error("Raise and lower active together");
    a_raise_on_sample: assert property ($rose(RAISE_O) |-> $past(line_rise))
        else $error("Raise started outside a positive half sample");
    a_raise_dir: assert property ($rose(RAISE_O) |-> $past(diff))
        else $error("Raise started on the wrong sign");
    a_lower_dir: assert property ($rose(LOWER_O) |-> !$past(diff))
        else $error("Lower started on the wrong sign");
    a_latch_held: assert property (RAISE_O && !done_evt |=> RAISE_O)
        else $error("Raise dropped before step complete");
    a_done_holds: assert property ((RAISE_O || LOWER_O) && done_evt
                                   |=> state_q == ST_HOLD
                                       && hold_q == HOLD_W'(HOLD_CYCLES - 1))
        else $error("Step end did not start the one-shot");
    a_hold_blocks: assert property (state_q == ST_HOLD && hold_q != '0 |=> state_q == ST_HOLD)
        else $error("Hold-off ended early");
    a_standby_quiet: assert property (ctrl_q.standby && state_q == ST_IDLE
                                      |=> state_q == ST_IDLE)
        else $error("Step accepted in standby");
    a_units_step: assert property (done_evt && RAISE_O && pos_q[3:0] != POS_TENTH
                                   |=> pos_q[3:0] == $past(pos_q[3:0]) + POS_ONE)
        else $error("Raise did not step the units decade");

    c_raise: cover property ($rose(RAISE_O));
    c_lower: cover property ($rose(LOWER_O));
    c_thousands: cover property (pos_q[15:12] != $past(pos_q[15:12]));
    c_hold_done: cover property (state_q == ST_HOLD ##1 state_q == ST_IDLE);

endmodule : nsbc_top

`default_nettype wire

// ==== nsbc_fix_note_unused.sv ====
// Holds no logic; the whole controller lives in nsbc_top.
// Assumes nothing of its surroundings.
`default_nettype none
`default_nettype wire

// ==== nsbc_partner.sv ====
// Far-side model: comparator front end and the four decade stepping switches.
// Assumes the controller's step lines and decade positions arrive at its ports.
`timescale 1ns/1ns
`default_nettype none

module nsbc_partner (
    input  wire logic        clk_i,        // Bench clock
    input  wire logic        rst_n_i,      // Async reset, active low
    input  wire logic        raise_i,      // Raise step line
    input  wire logic        lower_i,      // Lower step line
    input  wire logic [15:0] digits_i,     // Decade positions
    input  wire logic [15:0] target_i,     // Input magnitude in counts
    input  wire logic        line_en_i,    // Low: line held in negative half
    input  wire logic        slow_i,       // Slow armature travel
    output logic             line_o,       // Line reference
    output logic             cmp_sign_o,   // Input above divider
    output logic             cmp_null_o,   // Input equals divider
    output logic             step_done_o   // Step complete
);
    // =====================================================================
    // Divider and comparison
    // =====================================================================
    logic [15:0] value;       // Divider setting in counts
    logic [4:0]  line_cnt_q;  // Line phase, 32 cycles a period
    logic [3:0]  wait_q;      // Armature travel left
    logic        busy_q;      // A step is under way

    // Tenth position weighs ten counts of its decade
    assign value = 16'(digits_i[3:0]) + 16'(digits_i[7:4]) * 16'h000a
                 + 16'(digits_i[11:8]) * 16'h0064 + 16'(digits_i[15:12]) * 16'h03e8;
    assign cmp_sign_o = (target_i > value);
    assign cmp_null_o = (target_i == value);

    // =====================================================================
    // Line phase and stepping mechanism
    // =====================================================================
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_cnt_q  <= 5'h00;
            line_o      <= 1'b0;
            wait_q      <= 4'h0;
            busy_q      <= 1'b0;
            step_done_o <= 1'b0;
        end else begin
            line_cnt_q <= line_cnt_q + 5'h01;
            line_o     <= line_en_i & line_cnt_q[4];
            if (!busy_q) begin
                // Idle: arm travel time, start on any step line
                busy_q <= raise_i | lower_i;
                wait_q <= slow_i ? 4'hc : 4'h2;
            end else if (!raise_i && !lower_i) begin
                // Line released: contacts open again
                busy_q      <= 1'b0;
                step_done_o <= 1'b0;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end else begin
                // Armature pulled in: one completion per step
                step_done_o <= 1'b1;
            end
        end
    end
endmodule : nsbc_partner
`default_nettype wire

// ==== nsbc_top_tb_top.sv ====
// Self-checking bench for the null-seeking balance control.
// Assumes nsbc_pkg, nsbc_top and nsbc_partner are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module nsbc_top_tb_top
    import nsbc_pkg::*;
;

    typedef struct packed {
        logic [15:0] target;  // Input magnitude in counts
        logic [15:0] digits;  // Positions expected at null
    } nsbc_row_t;

    localparam int        HOLD_SIM = 8;  // Shortened hold-off
    localparam nsbc_row_t ROWS [4] = '{'{16'h0000, 16'h0000}, '{16'h0007, 16'h0007},
                                       '{16'h03e7, 16'h0999}, '{16'h052c, 16'h1324}};

    logic        mclk, rst_n, cmp_sign, cmp_null, line, step_done, wr, rd;
    logic        line_en, slow, raise, lower, ref_neg, sign_plus, sign_minus;
    logic [1:0]  addr, rng, dp, e;
    logic [7:0]  wdata;
    logic [15:0] target, rdata, digits;
    logic [3:0]  th;
    int          err_total, compares, n;

    always #50 mclk = ~mclk;

    nsbc_top #(.HOLD_CYCLES(HOLD_SIM)) nsbc_top_i (
        .MCLK_I(mclk), .RST_N_I(rst_n), .CMP_SIGN_I(cmp_sign), .CMP_NULL_I(cmp_null),
        .LINE_I(line), .STEP_DONE_I(step_done), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RAISE_O(raise), .LOWER_O(lower),
        .DIGITS_O(digits), .REF_NEG_O(ref_neg), .SIGN_PLUS_O(sign_plus),
        .SIGN_MINUS_O(sign_minus), .RANGE_O(rng), .DP_O(dp));

    nsbc_partner nsbc_partner_i (
        .clk_i(mclk), .rst_n_i(rst_n), .raise_i(raise), .lower_i(lower),
        .digits_i(digits), .target_i(target), .line_en_i(line_en), .slow_i(slow),
        .line_o(line), .cmp_sign_o(cmp_sign), .cmp_null_o(cmp_null),
        .step_done_o(step_done));

    // =====================================================================
    // Tasks
    // =====================================================================
    // Compare one value, count it, report a difference at once
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
    endtask : do_reset

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask : reg_wr

    // Read data stand one cycle, then fall back to zero
    task automatic reg_rd(input logic [1:0] a, input logic [15:0] exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, exp, "read data");
        @(posedge mclk);
        #1 chk(rdata, 16'h0000, "read data after");
    endtask : reg_rd

    // Wait, bounded, until the OR of both step lines shows the given level
    task automatic wait_lvl(input logic lvl, input int lim);
        n = 0;
        while ((raise | lower) !== lvl && n < lim) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n >= lim) chk(16'h0001, 16'h0000, "step line wait");
    endtask : wait_lvl

    task automatic tally_and_finish;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // =====================================================================
    // Monitors and watchdog
    // =====================================================================
    // Raise and lower must never overlap
    always @(negedge mclk) begin
        if (rst_n === 1'b1 && raise === 1'b1 && lower === 1'b1) begin
            chk(16'h0001, 16'h0000, "both step lines");
        end
    end

    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish;
    end

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        {mclk, rst_n, wr, rd, slow} = 5'h00;
        line_en = 1'b1;
        addr = 2'h0;
        wdata = 8'h00;
        target = 16'h0000;
        err_total = 0;
        compares = 0;
        do_reset;
        #1 chk(16'({ref_neg, sign_plus, sign_minus, raise, lower}), 16'h0008, "reset");
        chk(digits, POS_RST, "reset digits");
        reg_rd(ADDR_STAT, 16'h0001);
        reg_rd(2'h3, 16'h0000);
        reg_wr(ADDR_DIGITS, 8'hff);
        reg_rd(ADDR_DIGITS, 16'h0000);
        $display("reset test done");
        // Ordinary cases: converge from zero to each target
        foreach (ROWS[i]) begin
            do_reset;
            target <= ROWS[i].target;
            n = 0;
            do begin
                @(posedge mclk);
                #1 n++;
            end while (cmp_null !== 1'b1 && n < 4000);
            chk(digits, ROWS[i].digits, "null digits");
            repeat (64) @(posedge mclk);
            #1 chk(16'({raise, lower}), 16'h0000, "rest at null");
            chk(digits, ROWS[i].digits, "digits at null");
            $display("row %0d done", i);
        end
        // One slow step: line held to completion, then hold-off
        do_reset;
        slow   <= 1'b1;
        target <= 16'h0005;
        wait_lvl(1'b1, 200);
        chk(16'({raise, lower}), 16'h0002, "raise chosen");
        repeat (8) @(posedge mclk);
        #1 chk(16'(raise), 16'h0001, "raise held");
        wait_lvl(1'b0, 100);
        chk(digits, 16'h0001, "units stepped");
        reg_rd(ADDR_STAT, 16'h0008);
        slow <= 1'b0;
        $display("hold test done");
        // Negative half and standby block all steps
        do_reset;
        line_en <= 1'b0;
        repeat (100) @(posedge mclk);
        #1 chk(16'({raise, lower}), 16'h0000, "line low");
        chk(digits, 16'h0000, "line low digits");
        reg_wr(ADDR_CTRL, 8'h08);
        @(posedge mclk);
        line_en <= 1'b1;
        repeat (100) @(posedge mclk);
        #1 chk(16'({raise, lower}), 16'h0000, "standby");
        chk(digits, 16'h0000, "standby digits");
        reg_wr(ADDR_CTRL, 8'h00);
        wait_lvl(1'b1, 100);
        chk(16'(raise), 16'h0001, "standby left");
        $display("inhibit test done");
        // Opposite polarity swaps paths and lamps
        do_reset;
        reg_wr(ADDR_CTRL, 8'h01);
        #1 chk(16'({ref_neg, sign_plus, sign_minus}), 16'h0005, "polarity");
        wait_lvl(1'b1, 200);
        chk(16'({raise, lower}), 16'h0001, "lower chosen");
        wait_lvl(1'b0, 100);
        chk(16'(digits[15:12]), 16'(POS_TENTH), "thousands wrap");
        $display("polarity test done");
        // Range codes and decimal point, code 3 kept as 2
        for (int r = 0; r < 4; r++) begin
            reg_wr(ADDR_CTRL, 8'(r * 2));
            e = (r == 3) ? RNG_DIV100 : 2'(r);
            #1 chk(16'({rng, dp}), 16'({e, e}), "range");
            reg_rd(ADDR_CTRL, 16'({e, 1'b0}));
        end
        $display("range test done");
        // Over range: lower decades stuck full, thousands turning
        do_reset;
        target <= 16'h4e20;
        n = 0;
        while (digits[11:0] !== 12'haaa && n < 3000) begin
            @(posedge mclk);
            #1 n++;
        end
        th = digits[15:12];
        repeat (100) @(posedge mclk);
        #1 chk(16'(digits[11:0]), 16'h0aaa, "over range");
        chk(16'(th != digits[15:12]), 16'h0001, "thousands turning");
        $display("over range test done");
        tally_and_finish;
    end
endmodule : nsbc_top_tb_top
`default_nettype wire
